//--- verilog/alc_pkg.sv
// constants, types and timing figures of the ambient light conversion control
// assumes a single core clock whose rate is given by ALC_CLK_HZ
package alc_pkg;
    localparam int ALC_CLK_HZ = 100000000;     // core clock rate in hertz
    localparam int T_SHORT_MS = 100;           // short integration, ms
    localparam int T_LONG_MS = 800;            // long integration, ms
    localparam int T_READY_MS = 3;             // result latency after integration, ms
    localparam int T_ASSESS_MS = 10;           // auto range assessment, ms
    localparam int T_TIMEOUT_MS = 28;          // bus low timeout, ms
    localparam int CYC_PER_MS = ALC_CLK_HZ / 1000;
    localparam int SHORT_CYC = T_SHORT_MS * CYC_PER_MS;
    localparam int LONG_CYC = T_LONG_MS * CYC_PER_MS;
    localparam int READY_CYC = T_READY_MS * CYC_PER_MS;
    localparam int ASSESS_CYC = T_ASSESS_MS * CYC_PER_MS;
    localparam int TIMEOUT_CYC = T_TIMEOUT_MS * CYC_PER_MS;
    localparam int TMR_W = 27;                 // wide enough for 803 ms
    localparam logic [1:0] MODE_OFF = 2'h0;    // shutdown
    localparam logic [1:0] MODE_SINGLE = 2'h1; // one conversion per command
    localparam logic [3:0] RANGE_AUTO = 4'hc;  // automatic full-scale code
    localparam logic [3:0] RANGE_MAX = 4'hb;   // highest fixed range
    localparam logic [11:0] MANT_MAX = 12'hfff;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [6:0] BUS_ADDR_RST = 7'h44; // default slave address
    // result word: exponent over twelve-bit mantissa
    typedef struct packed {
        logic [3:0] expo;
        logic [11:0] mant;
    } alc_result_t;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ASSESS = 2'b01,
        ST_INTEG = 2'b10,
        ST_FINISH = 2'b11
    } alc_state_t;
    typedef enum logic [2:0] {
        LK_ADDR = 3'b000,
        LK_AACK = 3'b001,
        LK_SEND = 3'b010,
        LK_MACK = 3'b011,
        LK_IDLE = 3'b100
    } alc_link_t;
endpackage

//--- verilog/alc_ctrl.sv
// ambient light conversion sequencer with a read-only serial result port
// assumes the front end presents a settled light level and that the bus
// master drives SCL; the serial logic runs on SCL itself
module alc_ctrl import alc_pkg::*; #(
    parameter int SHORT_CYCLES = SHORT_CYC,
    parameter int LONG_CYCLES = LONG_CYC,
    parameter int READY_CYCLES = READY_CYC,
    parameter int ASSESS_CYCLES = ASSESS_CYC,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter logic [6:0] BUS_ADDR = BUS_ADDR_RST
) (
    // clock, reset, enable
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    // configuration
    input wire logic [1:0] MODE_IN,
    input wire logic CONVERSION_TIME_SELECT_IN,
    input wire logic [3:0] RANGE_SELECT_FIELD_IN,
    input wire alc_result_t LOW_LIMIT_IN,
    input wire alc_result_t HIGH_LIMIT_IN,
    // light level from the front end
    input wire logic [22:0] LIGHT_LEVEL_IN,
    // serial bus pins
    input wire logic SCL_CLK_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    // interrupt pin
    input wire logic INT_IN,
    output logic INT_OUT,
    output logic INT_OE_N_OUT,
    // status
    output alc_result_t RESULT_OUT,
    output logic DATA_READY_OUT,
    output logic BUSY_OUT
);
    // lux value of a result word; 27 bits hold a limit with exponent fifteen
    function automatic logic [26:0] lux_of(input alc_result_t r);
        lux_of = 27'(r.mant) << r.expo;
    endfunction

    // smallest exponent that keeps the mantissa within twelve bits
    function automatic logic [3:0] fit_exp(input logic [22:0] lvl);
        fit_exp = RANGE_MAX;
        for (int i = 11; i >= 0; i--) begin
            if ((lvl >> i) <= 23'(MANT_MAX)) begin
                fit_exp = 4'(i);
            end
        end
    endfunction

    // ---------------- conversion sequencer ----------------
    alc_state_t state, next_state;           // sequencer state
    logic [TMR_W-1:0] tmr, next_tmr;         // down counter of current phase
    logic [3:0] expo, next_expo;             // range used by this conversion
    logic known, next_known;                 // auto range already assessed
    logic single_done, next_single_done;     // single shot consumed
    alc_result_t result, next_result;        // last stored result
    logic ready, next_ready;                 // one-cycle data ready
    logic int_act, next_int_act;             // result outside the window
    logic auto_rng;                          // automatic range selected
    logic active_req;                        // host wants conversions
    logic [3:0] fixed_exp;                   // clamped fixed range
    logic [TMR_W-1:0] integ_load;            // integration length minus one
    logic [22:0] shifted;                    // level scaled by the range
    logic [26:0] res_lux; // lux of the new result
    logic [11:0] sat_mant; // saturated mantissa of the new result

    assign auto_rng = (RANGE_SELECT_FIELD_IN == RANGE_AUTO);
    // a consumed single shot stays off until the mode leaves single
    assign active_req = (MODE_IN != MODE_OFF) &&
                        !((MODE_IN == MODE_SINGLE) && single_done);
    assign fixed_exp = (RANGE_SELECT_FIELD_IN > RANGE_MAX) ? RANGE_MAX
                                                           : RANGE_SELECT_FIELD_IN;
    assign integ_load = CONVERSION_TIME_SELECT_IN ? TMR_W'(LONG_CYCLES - 1)
                                                  : TMR_W'(SHORT_CYCLES - 1);
    assign shifted = LIGHT_LEVEL_IN >> expo;
    assign sat_mant = (shifted > 23'(MANT_MAX)) ? MANT_MAX : shifted[11:0];
    // built from expo and sat_mant so the next-value logic has no loop through itself
    assign res_lux = 27'(sat_mant) << expo;

    // next values of the sequencer
    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_expo = expo;
        next_known = known;
        next_single_done = single_done;
        next_result = result;
        next_ready = 1'b0;
        next_int_act = int_act;
        // the assessment is forgotten whenever auto range is deselected or shutdown is selected
        if (!auto_rng || (MODE_IN == MODE_OFF)) begin
            next_known = 1'b0;
        end
        if (MODE_IN != MODE_SINGLE) begin
            next_single_done = 1'b0;
        end
        case (state)
            ST_OFF: begin
                if (active_req && auto_rng && !known) begin
                    next_state = ST_ASSESS;
                    next_tmr = TMR_W'(ASSESS_CYCLES - 1);
                end else if (active_req) begin
                    next_state = ST_INTEG;
                    next_tmr = integ_load;
                    next_expo = auto_rng ? fit_exp(LIGHT_LEVEL_IN) : fixed_exp;
                end
            end
            ST_ASSESS: begin
                if (MODE_IN == MODE_OFF) begin
                    next_state = ST_OFF;
                end else if (tmr == '0) begin
                    // first full measurement on the assessed range
                    next_state = ST_INTEG;
                    next_tmr = integ_load;
                    next_known = 1'b1;
                    next_expo = fit_exp(LIGHT_LEVEL_IN);
                end else begin
                    next_tmr = tmr - 1'b1;
                end
            end
            ST_INTEG: begin
                if (MODE_IN == MODE_OFF) begin
                    next_state = ST_OFF;
                end else if (tmr == '0) begin
                    next_state = ST_FINISH;
                    next_tmr = TMR_W'(READY_CYCLES - 1);
                end else begin
                    next_tmr = tmr - 1'b1;
                end
            end
            ST_FINISH: begin
                if (MODE_IN == MODE_OFF) begin
                    next_state = ST_OFF;
                end else if (tmr == '0) begin
                    // store, flag ready and judge against the window
                    next_result.expo = expo;
                    next_result.mant = sat_mant;
                    next_ready = 1'b1;
                    next_int_act = (res_lux > lux_of(HIGH_LIMIT_IN)) ||
                                   (res_lux < lux_of(LOW_LIMIT_IN));
                    if (MODE_IN == MODE_SINGLE) begin
                        next_state = ST_OFF;
                        next_single_done = 1'b1;
                    end else begin
                        next_state = ST_INTEG;
                        next_tmr = integ_load;
                        next_expo = auto_rng ? fit_exp(LIGHT_LEVEL_IN) : fixed_exp;
                    end
                end else begin
                    next_tmr = tmr - 1'b1;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // sequencer registers; reset lands in shutdown
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state <= ST_OFF;
            tmr <= '0;
            expo <= 4'h0;
            known <= 1'b0;
            single_done <= 1'b0;
            result <= RESULT_RST;
            ready <= 1'b0;
            int_act <= 1'b0;
        end else if (CE_IN) begin
            state <= next_state;
            tmr <= next_tmr;
            expo <= next_expo;
            known <= next_known;
            single_done <= next_single_done;
            result <= next_result;
            ready <= next_ready;
            int_act <= next_int_act;
        end
    end

    assign RESULT_OUT = result;
    assign DATA_READY_OUT = ready;
    assign BUSY_OUT = (state != ST_OFF);
    // open drain, active low: pulled low while the result is outside
    assign INT_OUT = 1'b0;
    assign INT_OE_N_OUT = !int_act;

    // ---------------- bus monitor on the core clock ----------------
    logic [2:0] scl_sy, next_scl_sy;   // three-stage pin sampler
    logic [2:0] sda_sy, next_sda_sy;
    logic scl_f, next_scl_f;           // agreed pin levels
    logic sda_f, next_sda_f;
    logic bus_act, next_bus_act;       // between start and stop
    logic bus_rst, next_bus_rst;       // resets the serial engine
    logic [TMR_W-1:0] tmo, next_tmo;   // SCL low time
    alc_result_t link_word, next_link_word; // word the serial engine sends

    // next values of the monitor; a level counts once stages two and three agree
    always_comb begin
        next_scl_sy = {scl_sy[1:0], SCL_CLK_IN};
        next_sda_sy = {sda_sy[1:0], SDA_IN};
        next_scl_f = (scl_sy[2] == scl_sy[1]) ? scl_sy[2] : scl_f;
        next_sda_f = (sda_sy[2] == sda_sy[1]) ? sda_sy[2] : sda_f;
        next_bus_act = bus_act;
        next_bus_rst = 1'b0;
        next_tmo = '0;
        if (!scl_f) begin
            next_tmo = tmo + 1'b1;
        end
        // SDA that moves together with an SCL fall is data, not a start or stop
        if (scl_f && next_scl_f && sda_f && !next_sda_f) begin
            next_bus_act = 1'b1; // start
            next_bus_rst = 1'b1;
        end else if (scl_f && next_scl_f && !sda_f && next_sda_f) begin
            next_bus_act = 1'b0; // stop
            next_bus_rst = 1'b1;
        end
        if (!scl_f && (tmo == TMR_W'(TIMEOUT_CYCLES - 1))) begin
            next_bus_act = 1'b0;
            next_bus_rst = 1'b1;
            next_tmo = '0;
        end
        // the word only changes while no transfer runs, so it is static on SCL
        next_link_word = bus_act ? link_word : result;
    end

    // monitor registers
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            bus_act <= 1'b0;
            bus_rst <= 1'b0;
            tmo <= '0;
            link_word <= RESULT_RST;
        end else if (CE_IN) begin
            scl_sy <= next_scl_sy;
            sda_sy <= next_sda_sy;
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            bus_act <= next_bus_act;
            bus_rst <= next_bus_rst;
            tmo <= next_tmo;
            link_word <= next_link_word;
        end
    end

    // ---------------- serial engine on SCL ----------------
    // SCL stops between frames, so start, stop and timeout end the frame
    // through an asynchronous reset driven from a core flip-flop
    logic lrst_n;                        // engine reset, active low
    alc_link_t lst, next_lst;            // engine state
    logic [2:0] bcnt, next_bcnt;         // bit within byte
    logic [7:0] shreg, next_shreg;       // received address byte
    logic bsel, next_bsel;               // 0 high byte, 1 low byte
    logic drv_low, next_drv_low;         // pull SDA low on this low phase
    logic [7:0] tx_byte;                 // byte being sent

    assign lrst_n = NRST_IN && !bus_rst;
    assign tx_byte = bsel ? link_word[7:0] : link_word[15:8];

    // next values taken on the SCL rising edge
    always_comb begin
        next_lst = lst;
        next_bcnt = bcnt + 1'b1;
        next_shreg = {shreg[6:0], SDA_IN};
        next_bsel = bsel;
        case (lst)
            LK_ADDR: begin
                if (bcnt == 3'h7) begin
                    next_lst = (next_shreg == {BUS_ADDR, 1'b1}) ? LK_AACK : LK_IDLE;
                end
            end
            LK_AACK: begin
                next_lst = LK_SEND;
                next_bcnt = 3'h0;
                next_bsel = 1'b0;
            end
            LK_SEND: begin
                if (bcnt == 3'h7) begin
                    next_lst = LK_MACK;
                end
            end
            LK_MACK: begin
                // master ack on the high byte asks for the low byte
                next_lst = (!SDA_IN && !bsel) ? LK_SEND : LK_IDLE;
                next_bcnt = 3'h0;
                next_bsel = 1'b1;
            end
            LK_IDLE: begin
                next_bcnt = 3'h0;
            end
            default: begin
                next_lst = LK_IDLE;
            end
        endcase
    end

    // engine registers on the SCL rising edge
    always_ff @(posedge SCL_CLK_IN or negedge lrst_n) begin
        if (!lrst_n) begin
            lst <= LK_ADDR;
            bcnt <= 3'h0;
            shreg <= 8'h00;
            bsel <= 1'b0;
        end else begin
            lst <= next_lst;
            bcnt <= next_bcnt;
            shreg <= next_shreg;
            bsel <= next_bsel;
        end
    end

    // SDA changes only while SCL is low
    always_comb begin
        next_drv_low = 1'b0;
        if (lst == LK_AACK) begin
            next_drv_low = 1'b1;
        end else if (lst == LK_SEND) begin
            next_drv_low = !tx_byte[3'h7 - bcnt];
        end
    end

    always_ff @(negedge SCL_CLK_IN or negedge lrst_n) begin
        if (!lrst_n) begin
            drv_low <= 1'b0;
        end else begin
            drv_low <= next_drv_low;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_N_OUT = !drv_low;

    // ---------------- checks ----------------
    a_tmo_fire: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && !scl_f && tmo == TMR_W'(TIMEOUT_CYCLES - 1)) |=> (bus_rst && !bus_act))
        else $error("bus timeout did not reset the engine");
    a_tmo_restart: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && scl_f) |=> (tmo == '0))
        else $error("timeout counter ran while SCL high");
    a_integ_len: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && state != ST_INTEG && next_state == ST_INTEG) |=>
        (tmr == ($past(CONVERSION_TIME_SELECT_IN) ? TMR_W'(LONG_CYCLES - 1)
                                                  : TMR_W'(SHORT_CYCLES - 1))))
        else $error("integration length does not follow the time select");
    a_ready_lat: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && state == ST_INTEG && tmr == '0 && MODE_IN != MODE_OFF) |=>
        (state == ST_FINISH && tmr == TMR_W'(READY_CYCLES - 1)))
        else $error("ready latency not started at integration end");
    a_auto_assess: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && state == ST_OFF && active_req && auto_rng && !known) |=>
        (state == ST_ASSESS && tmr == TMR_W'(ASSESS_CYCLES - 1)))
        else $error("auto range entry skipped the assessment");
    a_off_hold: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && MODE_IN == MODE_OFF) |=> (state == ST_OFF && !ready))
        else $error("engine ran in shutdown mode");
    a_single_stop: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && state == ST_FINISH && tmr == '0 && MODE_IN == MODE_SINGLE) |=>
        (ready && state == ST_OFF && single_done))
        else $error("single shot did not return to shutdown");
    a_auto_fit: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (CE_IN && state == ST_OFF && active_req && auto_rng && known) |=>
        (expo == fit_exp($past(LIGHT_LEVEL_IN))))
        else $error("auto range not fitted to the light level");
    a_int_window: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        ready |-> (INT_OE_N_OUT == !((lux_of(result) > lux_of(HIGH_LIMIT_IN)) ||
                                     (lux_of(result) < lux_of(LOW_LIMIT_IN)))))
        else $error("interrupt pin disagrees with the window");
endmodule

//--- testbench/alc_i2c_master.sv
// serial bus master model that reads the result word from the device
// assumes the bench wires sda with a pull-up and feeds the level back
module alc_i2c_master (
    // bus pins
    output logic scl_out,
    output logic sda_out,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // both lines released outside frames, so the clock stands high
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // one 160 ns bit slot: data moves mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        #40 sda_out = b;
        #40 scl_out = 1'b1;
        #40 r = sda_in;
        #40 scl_out = 1'b0;
    endtask
    // odd offset keeps the bus clock out of step with the core clock
    task automatic start_frame();
        #13.7 sda_out = 1'b1;
        #80 sda_out = 1'b0;
        #80 scl_out = 1'b0;
    endtask
    task automatic stop_frame();
        #40 sda_out = 1'b0;
        #40 scl_out = 1'b1;
        #80 sda_out = 1'b1;
        #80;
    endtask
    // address byte msb first; ack is high when the ninth bit came back low
    task automatic address(input logic [7:0] ab, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(ab[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // whole read: high byte, master ack, low byte, master nack, stop
    task automatic read_word(input logic [7:0] ab, output logic ack, output logic [15:0] d);
        logic r;
        d = 16'hffff;
        start_frame();
        address(ab, ack);
        if (ack) begin
            for (int i = 15; i >= 0; i--) begin
                bit_io(1'b1, d[i]);
                if (i % 8 == 0) begin
                    bit_io(i == 0, r);
                end
            end
        end
        stop_frame();
    endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench of the light conversion control and its serial port
// assumes the design package and the serial master model compile first
module testbench;
    import alc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // shortened counts keep the run brief; all expected latencies derive from them
    localparam int SHORT = 40;
    localparam int LONG = 80;
    localparam int READY = 6;
    localparam int ASSESS = 10;
    localparam int TOUT = 50;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode = MODE_OFF;
    logic time_sel = 1'b0;
    logic [3:0] range_sel = 4'h0;
    logic ce = 1'b1; // clock enable of the design
    alc_result_t low_lim = '0;
    alc_result_t high_lim = '0;
    logic [22:0] level = 23'h0;
    logic scl, sda_m, sda, sda_oe_n, sda_o, int_oe_n, int_o, ready, busy, ack;
    alc_result_t result;
    logic [15:0] word;
    logic [15:0] exp_res; // word the model predicts
    logic [31:0] lfsr = 32'h1586;
    int mismatches = 0;
    int cmp_count = 0;
    // pulled-up open-drain lines: any party pulling low wins
    assign sda = sda_m & (sda_oe_n | sda_o);
    always #5 clk = ~clk;
    alc_ctrl #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG), .READY_CYCLES(READY),
        .ASSESS_CYCLES(ASSESS), .TIMEOUT_CYCLES(TOUT)) DUT (
        .CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .MODE_IN(mode),
        .CONVERSION_TIME_SELECT_IN(time_sel), .RANGE_SELECT_FIELD_IN(range_sel),
        .LOW_LIMIT_IN(low_lim), .HIGH_LIMIT_IN(high_lim), .LIGHT_LEVEL_IN(level),
        .SCL_CLK_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n),
        .INT_IN(int_oe_n | int_o), .INT_OUT(int_o), .INT_OE_N_OUT(int_oe_n),
        .RESULT_OUT(result), .DATA_READY_OUT(ready), .BUSY_OUT(busy));
    alc_i2c_master MST (.scl_out(scl), .sda_out(sda_m), .sda_in(sda));
    // compare tasks, one per kind of result
    task automatic chk_bit(input logic got, input logic want, input string what);
        cmp_count++;
        if (got !== want) begin
            mismatches++;
            $display("BAD %0t %s got %b want %b", $time, what, got, want);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] want, input string what);
        cmp_count++;
        if (got !== want) begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic chk_count(input int got, input int want, input string what);
        cmp_count++;
        if (got != want) begin
            mismatches++;
            $display("BAD %0t %s got %0d want %0d", $time, what, got, want);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // inputs other than the bus pins always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // integer model: exponent over saturating mantissa, auto takes the smallest fit
    function automatic logic [15:0] model_res(input int lvl, input int code);
        int e;
        int m;
        e = (code > 11) ? 11 : code;
        if (code == 12) begin
            e = 0;
            while (e < 11 && (lvl >> e) > 4095) e++;
        end
        m = ((lvl >> e) > 4095) ? 4095 : (lvl >> e);
        return {e[3:0], m[11:0]};
    endfunction
    function automatic logic outside(input logic [15:0] r, input logic [15:0] lo,
        input logic [15:0] hi);
        int v;
        int vl;
        int vh;
        v = r[11:0] << r[15:12];
        vl = lo[11:0] << lo[15:12];
        vh = hi[11:0] << hi[15:12];
        return (v < vl) || (v > vh);
    endfunction
    // fresh: pass through shutdown, new level and window, then start
    task automatic convert(input logic [1:0] md, input logic t, input logic [3:0] code,
        input int lat, input bit fresh);
        int n;
        logic [31:0] a;
        logic [31:0] b;
        if (fresh) begin
            mode = MODE_OFF;
            tick(1);
            a = rnd();
            b = rnd();
            level = a[22:0] >> a[26:23];
            low_lim = b[0] ? 16'h0000 : {4'h0, b[11:0]};
            high_lim = b[0] ? 16'hffff : b[31:16];
            exp_res = model_res(level, code);
            mode = md;
            time_sel = t;
            range_sel = code;
        end
        n = 0;
        do begin
            tick(1);
            n++;
        end while (ready !== 1'b1 && n < 2000);
        chk_count(n, lat, "ready latency");
        chk_word(result, exp_res, "result word");
        chk_bit(int_oe_n, ~outside(exp_res, low_lim, high_lim), "window pin");
        chk_bit(busy, md != MODE_SINGLE, "busy after result");
    endtask
    // hang guard, well beyond the expected run time
    initial begin
        #300000;
        mismatches++;
        finish_test();
    end
    initial begin
        int nr;
        tick(3);
        nrst = 1'b1;
        chk_bit(busy, 1'b0, "busy at reset");
        chk_word(result, RESULT_RST, "result at reset");
        chk_bit(int_oe_n, 1'b1, "pin at reset");
        tick(20);
        chk_bit(busy, 1'b0, "idle in shutdown");
        for (int c = 0; c < 16; c++) begin
            convert(MODE_SINGLE, 1'b0, c[3:0], (c == 12 ? ASSESS : 0) + SHORT + READY + 1, 1'b1);
        end
        tick(10);
        chk_bit(busy, 1'b0, "no second single shot");
        // a finished auto single shot keeps its assessment into continuous mode
        convert(MODE_SINGLE, 1'b0, 4'hc, ASSESS + SHORT + READY + 1, 1'b1);
        mode = 2'h2;
        convert(2'h2, 1'b0, 4'hc, SHORT + READY + 1, 1'b0);
        convert(MODE_SINGLE, 1'b1, 4'h3, LONG + READY + 1, 1'b1);
        for (int k = 2; k < 4; k++) begin
            convert(k[1:0], 1'b0, 4'h5, SHORT + READY + 1, 1'b1);
            convert(k[1:0], 1'b0, 4'h5, SHORT + READY, 1'b0);
        end
        // a low clock enable freezes the running conversion, so time spent frozen
        // must not shorten the wait for the next result
        ce = 1'b0;
        tick(20);
        ce = 1'b1;
        convert(2'h3, 1'b0, 4'h5, SHORT + READY, 1'b0);
        tick(10);
        mode = MODE_OFF;
        tick(2);
        chk_bit(busy, 1'b0, "abort");
        nr = 0;
        for (int i = 0; i < SHORT + READY + 5; i++) begin
            tick(1);
            nr += (ready === 1'b1);
        end
        chk_count(nr, 0, "result after abort");
        // hold the clock low mid-frame while the device drives bit 15 low
        MST.start_frame();
        MST.address({BUS_ADDR_RST, 1'b1}, ack);
        tick(TOUT - 10);
        chk_bit(sda_oe_n, 1'b0, "driving before timeout");
        tick(20);
        chk_bit(sda_oe_n, 1'b1, "released after timeout");
        MST.stop_frame();
        for (int k = 0; k < 3; k++) begin
            MST.read_word({BUS_ADDR_RST ^ {6'h0, k == 1}, k != 2}, ack, word);
            chk_bit(ack, k == 0, "address ack");
            if (k == 0) begin
                chk_word(word, exp_res, "serial word");
            end
        end
        finish_test();
    end
endmodule
